// ==== hw/ucsp_regs.vh ====
`ifndef UCSP_REGS_VH
`define UCSP_REGS_VH
// Register byte offsets
`define UCSP_MODE_OFF 8'h00
`define UCSP_STAT_OFF 8'h04
`define UCSP_CMD_OFF 8'h08
`define UCSP_RXDATA_OFF 8'h0c
`define UCSP_CHG_OFF 8'h10
`define UCSP_ISR_OFF 8'h14
`define UCSP_IMR_OFF 8'h18
`define UCSP_EVT_OFF 8'h1c
`define UCSP_IVR_OFF 8'h30
`define UCSP_CTS_OFF 8'h34
`define UCSP_RTSSET_OFF 8'h38
`define UCSP_RTSCLR_OFF 8'h3c
`define UCSP_FLAGS_OFF 8'h40
// Command register fields
`define UCSP_MISC_LSB 4
`define UCSP_MISC_MSB 6
`define UCSP_RXEN_BIT 0
`define UCSP_RXDIS_BIT 1
`define UCSP_TXEN_BIT 2
`define UCSP_TXDIS_BIT 3
// Miscellaneous command codes
`define UCSP_CMD_NONE 3'h0
`define UCSP_CMD_PTR 3'h1
`define UCSP_CMD_RXRST 3'h2
`define UCSP_CMD_TXRST 3'h3
`define UCSP_CMD_ERRRST 3'h4
`define UCSP_CMD_BRKRST 3'h5
// Serial status bits
`define UCSP_ST_RX_CHAR_READY_FLAG 0
`define UCSP_ST_RX_FIFO_FULL_FLAG 1
`define UCSP_ST_TX_HOLDING_READY_FLAG 2
`define UCSP_ST_TX_EMPTY_FLAG 3
`define UCSP_ST_OE 4
`define UCSP_ST_PE 5
`define UCSP_ST_FE 6
`define UCSP_ST_RB 7
// Interrupt status bits
`define UCSP_IS_TX_HOLDING_READY_FLAG 0
`define UCSP_IS_RX_CHAR_READY_FLAG 1
`define UCSP_IS_DBRK 2
`define UCSP_IS_CTSCHG 7
// Event injection bits
`define UCSP_EV_RB 0
`define UCSP_EV_FE 1
`define UCSP_EV_PE 2
`define UCSP_EV_OE 3
`define UCSP_EV_DBRK 4
// Reset value and receive FIFO depth
`define UCSP_IVR_RST 8'h0f
`define UCSP_RX_DEPTH 2'd3
`endif

// ==== hw/ucsp_rx_fifo.v ====
`timescale 1ns/100ps
`default_nettype none
module ucsp_rx_fifo (
  input wire pclk,
  input wire presetn,
  input wire flush,
  input wire push,
  input wire [7:0] push_data,
  input wire pop,
  output reg [7:0] rd_data_q,
  output reg [1:0] count_q
);
  reg [7:0] mem_q [0:3];
  reg [1:0] wr_q;
  reg [1:0] rd_q;
  wire do_push;
  wire do_pop;
  assign do_push = push && (count_q != 2'd3);
  assign do_pop = pop && (count_q != 2'd0);
  always @(posedge pclk) begin
    if (do_push) begin
      mem_q[wr_q] <= push_data;
    end
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_q <= 2'd0;
      rd_q <= 2'd0;
      count_q <= 2'd0;
      rd_data_q <= 8'hff;
    end else if (flush) begin
      // Pointers back to start leaves nothing stale
      wr_q <= 2'd0;
      rd_q <= 2'd0;
      count_q <= 2'd0;
      rd_data_q <= 8'hff;
    end else begin
      if (do_push) begin
        wr_q <= (wr_q == 2'd2) ? 2'd0 : wr_q + 2'd1;
      end
      if (do_pop) begin
        rd_data_q <= mem_q[rd_q];
        rd_q <= (rd_q == 2'd2) ? 2'd0 : rd_q + 2'd1;
      end
      if (do_push && !do_pop) begin
        count_q <= count_q + 2'd1;
      end else if (do_pop && !do_push) begin
        count_q <= count_q - 2'd1;
      end
    end
  end
endmodule
`default_nettype wire

// ==== hw/ucsp_top.v ====
`timescale 1ns/100ps
`default_nettype none
`include "ucsp_regs.vh"
// Behaviour
// - Pointer-reset command selects first mode register
// - Receiver reset disables, clears flags, resets FIFO
// - Transmitter reset disables, clears empty/ready flags
// - Error reset clears break, framing, parity, overrun
// - Break-change reset clears delta-break flag
// - Vector register holds 8-bit handler offset
// - Vector register resets to 0x0f
// - Input port bit reports clear-to-send level
// - Level latched at moment of read
// - Same value as change register bit 0
// - Set address sets, clear address clears RTS
// - Writing zero leaves RTS unchanged
// - RTS pin is inverted output bit
// - Mode pointer advances after first register access
module ucsp_top (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire cts_n_pin,
  input wire rx_push,
  input wire [7:0] rx_push_data,
  input wire tx_done,
  output reg rts_n_pin,
  output reg rx_enabled_q,
  output reg tx_enabled_q,
  output reg irq_q
);
  reg [7:0] first_mode_reg_q;
  reg [7:0] second_mode_reg_q;
  reg mode_ptr_q;
  reg [7:0] irq_vector_number_q;
  reg [7:0] irq_mask_q;
  reg [7:0] irq_status_sticky_q;
  reg [3:0] err_flags_q;
  reg tx_empty_flag_q;
  reg tx_holding_ready_flag_q;
  reg rts_bit_q;
  reg cts_meta_q;
  reg cts_sync_q;
  reg cts_prev_q;
  reg cts_delta_q;
  reg [7:0] rdata_d;
  reg rd_err_d;
  wire [7:0] fifo_data;
  wire [1:0] fifo_count;
  wire rx_char_ready_flag;
  wire rx_fifo_full_flag;
  wire [7:0] serial_status_reg;
  wire [7:0] irq_status_reg;
  wire [7:0] input_change_reg;
  wire [7:0] cts_input_sample;
  wire access;
  wire wr_en;
  wire rd_en;
  wire [2:0] misc_cmd;
  wire cmd_wr;
  wire rx_reset;
  wire tx_reset;
  wire err_reset;
  wire brk_reset;
  wire pop;
  wire [7:0] ev;
  wire cts_edge;
  wire setup;
  wire wr_evt;
  wire wr_isr;
  wire wr_imr;
  wire wr_ivr;
  wire rts_set;
  wire rts_clr;
  wire rd_chg;
  wire mode_acc;
  wire ptr_reset;
  wire delta_break_flag;
  wire [7:0] isr_clr;
  wire [7:0] isr_set;

  function is_off;
    input [7:0] a;
    input [7:0] off;
    begin
      is_off = (a == off);
    end
  endfunction

  assign access = psel && penable && !pready;
  assign wr_en = access && pwrite;
  assign rd_en = access && !pwrite;
  assign cmd_wr = wr_en && is_off(paddr, `UCSP_CMD_OFF);
  assign misc_cmd = pwdata[`UCSP_MISC_MSB:`UCSP_MISC_LSB];
  assign rx_reset = cmd_wr && (misc_cmd == `UCSP_CMD_RXRST);
  assign tx_reset = cmd_wr && (misc_cmd == `UCSP_CMD_TXRST);
  assign err_reset = cmd_wr && (misc_cmd == `UCSP_CMD_ERRRST);
  assign brk_reset = cmd_wr && (misc_cmd == `UCSP_CMD_BRKRST);
  assign setup = psel && !penable;
  // Pop in setup so the registered FIFO word is ready at the access edge
  assign pop = setup && !pwrite && is_off(paddr, `UCSP_RXDATA_OFF);
  assign wr_evt = wr_en && is_off(paddr, `UCSP_EVT_OFF);
  assign wr_isr = wr_en && is_off(paddr, `UCSP_ISR_OFF);
  assign wr_imr = wr_en && is_off(paddr, `UCSP_IMR_OFF);
  assign wr_ivr = wr_en && is_off(paddr, `UCSP_IVR_OFF);
  assign rts_set = wr_en && is_off(paddr, `UCSP_RTSSET_OFF) && pwdata[0];
  assign rts_clr = wr_en && is_off(paddr, `UCSP_RTSCLR_OFF) && pwdata[0];
  assign rd_chg = rd_en && is_off(paddr, `UCSP_CHG_OFF);
  assign mode_acc = access && is_off(paddr, `UCSP_MODE_OFF);
  assign ptr_reset = cmd_wr && (misc_cmd == `UCSP_CMD_PTR);
  assign ev = wr_evt ? pwdata[7:0] : 8'h00;
  assign cts_edge = cts_sync_q ^ cts_prev_q;

  ucsp_rx_fifo u_fifo (
    .pclk(pclk),
    .presetn(presetn),
    .flush(rx_reset),
    .push(rx_push && rx_enabled_q),
    .push_data(rx_push_data),
    .pop(pop),
    .rd_data_q(fifo_data),
    .count_q(fifo_count)
  );

  assign rx_char_ready_flag = (fifo_count != 2'd0);
  assign rx_fifo_full_flag = (fifo_count == `UCSP_RX_DEPTH);
  assign serial_status_reg = {err_flags_q, tx_empty_flag_q,
    tx_holding_ready_flag_q, rx_fifo_full_flag, rx_char_ready_flag};
  // Change register bit 0 is the synchronised CTS level
  assign input_change_reg = {cts_delta_q, 6'h00, cts_sync_q};
  assign cts_input_sample = {7'h7f, cts_sync_q};
  assign irq_status_reg = irq_status_sticky_q;
  assign delta_break_flag = irq_status_sticky_q[`UCSP_IS_DBRK];
  // Break-change reset clears the delta-break bit
  assign isr_clr = (wr_isr ? pwdata[7:0] : 8'h00) |
    (brk_reset ? (8'h01 << `UCSP_IS_DBRK) : 8'h00);
  assign isr_set = {cts_edge, 4'h0, ev[`UCSP_EV_DBRK], rx_char_ready_flag,
    tx_holding_ready_flag_q};

  // Pin passes two flops before use
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cts_meta_q <= 1'b1;
      cts_sync_q <= 1'b1;
      cts_prev_q <= 1'b1;
    end else begin
      cts_meta_q <= cts_n_pin;
      cts_sync_q <= cts_meta_q;
      cts_prev_q <= cts_sync_q;
    end
  end

  // Mode registers and pointer
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_mode_reg_q <= 8'h00;
      second_mode_reg_q <= 8'h00;
      mode_ptr_q <= 1'b0;
    end else begin
      if (mode_acc) begin
        if (pwrite && !mode_ptr_q) begin
          first_mode_reg_q <= pwdata[7:0];
        end else if (pwrite) begin
          second_mode_reg_q <= pwdata[7:0];
        end
        mode_ptr_q <= 1'b1;
      end
      if (ptr_reset) begin
        mode_ptr_q <= 1'b0;
      end
    end
  end

  // Receiver enable
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_enabled_q <= 1'b0;
    end else begin
      if (cmd_wr && pwdata[`UCSP_RXEN_BIT]) begin
        rx_enabled_q <= 1'b1;
      end
      if (cmd_wr && pwdata[`UCSP_RXDIS_BIT]) begin
        rx_enabled_q <= 1'b0;
      end
      // Receiver reset, FIFO flushed in u_fifo
      if (rx_reset) begin
        rx_enabled_q <= 1'b0;
      end
    end
  end

  // Transmitter enable and its flags
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_enabled_q <= 1'b0;
      tx_empty_flag_q <= 1'b0;
      tx_holding_ready_flag_q <= 1'b0;
    end else begin
      if (cmd_wr && pwdata[`UCSP_TXEN_BIT]) begin
        tx_enabled_q <= 1'b1;
        tx_empty_flag_q <= 1'b1;
        tx_holding_ready_flag_q <= 1'b1;
      end
      if (cmd_wr && pwdata[`UCSP_TXDIS_BIT]) begin
        tx_enabled_q <= 1'b0;
      end
      if (tx_done && tx_enabled_q) begin
        tx_empty_flag_q <= 1'b1;
        tx_holding_ready_flag_q <= 1'b1;
      end
      if (tx_reset) begin
        tx_enabled_q <= 1'b0;
        tx_empty_flag_q <= 1'b0;
        tx_holding_ready_flag_q <= 1'b0;
      end
    end
  end

  // Error flags
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_flags_q <= 4'h0;
    end else begin
      // Error clear, then new events win
      if (err_reset) begin
        err_flags_q <= 4'h0;
      end
      if (ev[3:0] != 4'h0) begin
        err_flags_q <= (err_reset ? 4'h0 : err_flags_q) |
          {ev[`UCSP_EV_RB], ev[`UCSP_EV_FE], ev[`UCSP_EV_PE],
           ev[`UCSP_EV_OE]};
      end
    end
  end

  // CTS change flag, an edge beats a clearing read
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cts_delta_q <= 1'b0;
    end else begin
      if (cts_edge) begin
        cts_delta_q <= 1'b1;
      end else if (rd_chg) begin
        cts_delta_q <= 1'b0;
      end
    end
  end

  // Vector and mask registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_vector_number_q <= `UCSP_IVR_RST;
      irq_mask_q <= 8'h00;
    end else begin
      if (wr_ivr) begin
        irq_vector_number_q <= pwdata[7:0];
      end
      if (wr_imr) begin
        irq_mask_q <= pwdata[7:0];
      end
    end
  end

  // Request-to-send bit
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rts_bit_q <= 1'b0;
    end else begin
      // Only ones in bit 0 act
      if (rts_set) begin
        rts_bit_q <= 1'b1;
      end
      if (rts_clr) begin
        rts_bit_q <= 1'b0;
      end
    end
  end

  // Sticky interrupt status, write one to clear, set wins
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status_sticky_q <= 8'h00;
    end else begin
      irq_status_sticky_q <= (irq_status_sticky_q & ~isr_clr) | isr_set;
    end
  end

  always @* begin
    rdata_d = 8'h00;
    rd_err_d = 1'b0;
    case (paddr)
      `UCSP_MODE_OFF: rdata_d = mode_ptr_q ? second_mode_reg_q :
        first_mode_reg_q;
      `UCSP_STAT_OFF: rdata_d = serial_status_reg;
      `UCSP_RXDATA_OFF: rdata_d = fifo_data;
      `UCSP_CHG_OFF: rdata_d = input_change_reg;
      `UCSP_ISR_OFF: rdata_d = irq_status_reg;
      `UCSP_IMR_OFF: rdata_d = irq_mask_q;
      `UCSP_IVR_OFF: rdata_d = irq_vector_number_q;
      `UCSP_CTS_OFF: rdata_d = cts_input_sample;
      `UCSP_FLAGS_OFF: rdata_d = {5'h00, delta_break_flag,
        tx_enabled_q, rx_enabled_q};
      `UCSP_CMD_OFF, `UCSP_EVT_OFF, `UCSP_RTSSET_OFF,
      `UCSP_RTSCLR_OFF: rdata_d = 8'h00;
      default: rd_err_d = 1'b1;
    endcase
  end

  // One wait state: answer registered at access phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      rts_n_pin <= 1'b1;
      irq_q <= 1'b0;
    end else begin
      pready <= access;
      pslverr <= access && rd_err_d;
      if (rd_en) begin
        prdata <= {24'h000000, rdata_d};
      end
      rts_n_pin <= ~rts_bit_q;
      irq_q <= |(irq_status_sticky_q & irq_mask_q);
    end
  end
endmodule
`default_nettype wire

// ==== sim/ucsp_asserts.sv ====
`timescale 1ns/100ps
`default_nettype none
module ucsp_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic rts_n_pin,
  input wire logic rx_enabled_q,
  input wire logic tx_enabled_q
);
  wire tk = psel && penable && !pready;
  wire wr = tk && pwrite;
  wire set1 = wr && paddr == 8'h38 && pwdata[0];
  wire clr = wr && paddr == 8'h3c;
  wire [2:0] cmd = pwdata[6:4];
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_ready_next: assert property (tk |=> pready)
    else $error("no ready after access");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held too long");
  chk_err_ready: assert property (pslverr |-> pready && $past(tk))
    else $error("error without answer");
  chk_rts_set: assert property (
    $fell(rts_n_pin) |-> $past(set1) || $past(set1, 2))
    else $error("rts asserted without set write");
  chk_rts_clear: assert property (
    $rose(rts_n_pin) |-> $past(clr) || $past(clr, 2))
    else $error("rts released without clear write");
  chk_rts_zero: assert property (
    wr && paddr == 8'h38 && !pwdata[0] |=> $stable(rts_n_pin) [*2])
    else $error("zero write moved rts");
  chk_rx_reset: assert property (
    wr && paddr == 8'h08 && cmd == 3'h2 |=> ##[0:1] !rx_enabled_q)
    else $error("receiver still enabled");
  chk_tx_reset: assert property (
    wr && paddr == 8'h08 && cmd == 3'h3 |=> ##[0:1] !tx_enabled_q)
    else $error("transmitter still enabled");
  cover property (wr && paddr == 8'h08 && cmd == 3'h2);
  cover property ($fell(rts_n_pin));
  cover property (pslverr);
endmodule
bind ucsp_top ucsp_asserts chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .rts_n_pin(rts_n_pin), .rx_enabled_q(rx_enabled_q),
  .tx_enabled_q(tx_enabled_q));
`default_nettype wire

// ==== sim/ucsp_peer.sv ====
`timescale 1ns/100ps
`default_nettype none
module ucsp_peer (
  input wire logic pclk,
  input wire logic rts_n_pin,
  output logic cts_n_pin,
  output logic rx_push,
  output logic [7:0] rx_push_data,
  output logic tx_done
);
  initial begin
    cts_n_pin = 1'b1;
    rx_push = 1'b0;
    rx_push_data = 8'h00;
    tx_done = 1'b0;
  end
  // Sends only while our request line is asserted
  task send(input logic [7:0] v);
    while (rts_n_pin !== 1'b0) @(posedge pclk);
    @(posedge pclk);
    rx_push <= 1'b1;
    rx_push_data <= v;
    @(posedge pclk);
    rx_push <= 1'b0;
    rx_push_data <= ~v;
  endtask
  task done;
    @(posedge pclk);
    tx_done <= 1'b1;
    @(posedge pclk);
    tx_done <= 1'b0;
  endtask
  task set_cts(input logic v);
    @(posedge pclk);
    cts_n_pin <= v;
  endtask
endmodule
`default_nettype wire

// ==== sim/ucsp_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_fail++; \
  $display("wrong value at %0t: %h vs %h", $time, g, e); end end
module testbench;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00, rx_push_data, d;
  logic [31:0] pwdata = 0, prdata;
  logic pready, pslverr, cts_n_pin, rx_push, tx_done, rts_n_pin;
  logic rx_enabled_q, tx_enabled_q, irq_q;
  logic [16:0] q[$];
  logic [16:0] e;
  int n_fail = 0, checked = 0, cyc = 0, i;
  initial forever #4 pclk = ~pclk;
  ucsp_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cts_n_pin(cts_n_pin), .rx_push(rx_push),
    .rx_push_data(rx_push_data), .tx_done(tx_done),
    .rts_n_pin(rts_n_pin), .rx_enabled_q(rx_enabled_q),
    .tx_enabled_q(tx_enabled_q), .irq_q(irq_q));
  ucsp_peer peer (.pclk(pclk), .rts_n_pin(rts_n_pin),
    .cts_n_pin(cts_n_pin), .rx_push(rx_push),
    .rx_push_data(rx_push_data), .tx_done(tx_done));
  task final_report;
    $display("checks %0d, mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Entry: mask, error, data; data ignored where mask is 0
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_fail++;
      final_report();
    end
    if (pready === 1'b1 && !pwrite) begin
      e = q.pop_front();
      `CHK({pslverr, prdata[7:0] & e[16:9]}, {e[8], e[7:0] & e[16:9]})
    end
  end
  task apb(input logic w, input logic [7:0] a, input logic [31:0] v);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] v);
    apb(1'b1, a, v);
  endtask
  task rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] x);
    q.push_back({m, 1'b0, x});
    apb(1'b0, a, 32'h0);
  endtask
  task cmd(input logic [2:0] c, input logic [3:0] en);
    wr(8'h08, {25'h0, c, en});
  endtask
  // Lets pin synchronisers and output flops land
  task settle;
    repeat (3) @(posedge pclk);
    #1;
  endtask
  initial begin
    d = 8'($urandom(28));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    `CHK(rts_n_pin, 1'b1)
    rd(8'h30, 8'hff, 8'h0f);
    d = 8'($urandom);
    wr(8'h30, {24'h0, d});
    rd(8'h30, 8'hff, d);
    for (i = 0; i < 4; i++) begin
      d = 8'($urandom);
      peer.set_cts(d[0]);
      settle();
      rd(8'h34, 8'hff, {7'h7f, d[0]});
      rd(8'h10, 8'h01, {7'h0, d[0]});
    end
    for (i = 0; i < 5; i++) begin
      wr(i == 2 ? 8'h3c : 8'h38, {31'h0, i != 1 && i != 3});
      settle();
      `CHK(rts_n_pin, i == 2 || i == 3)
    end
    d = 8'($urandom);
    wr(8'h00, {24'h0, d});
    wr(8'h00, {24'h0, ~d});
    cmd(3'h1, 4'h0);
    rd(8'h00, 8'hff, d);
    rd(8'h00, 8'hff, ~d);
    cmd(3'h0, 4'h1);
    for (i = 0; i < 4; i++) peer.send(8'($urandom));
    rd(8'h04, 8'h03, 8'h03);
    cmd(3'h2, 4'h0);
    `CHK(rx_enabled_q, 1'b0)
    rd(8'h04, 8'h03, 8'h00);
    cmd(3'h0, 4'h1);
    d = 8'($urandom);
    peer.send(d);
    rd(8'h0c, 8'hff, d);
    cmd(3'h0, 4'h4);
    peer.done();
    peer.send(8'($urandom));
    rd(8'h04, 8'h0c, 8'h0c);
    cmd(3'h3, 4'h0);
    `CHK(tx_enabled_q, 1'b0)
    rd(8'h04, 8'h0d, 8'h01);
    d = {4'h0, 4'($urandom)} | 8'h01;
    wr(8'h1c, {24'h0, d});
    rd(8'h04, 8'hf0, {d[0], d[1], d[2], d[3], 4'h0});
    cmd(3'h4, 4'h0);
    rd(8'h04, 8'hf0, 8'h00);
    wr(8'h1c, 32'h10);
    settle();
    `CHK(irq_q, 1'b0)
    rd(8'h14, 8'h04, 8'h04);
    wr(8'h18, 32'h4);
    settle();
    `CHK(irq_q, 1'b1)
    cmd(3'h5, 4'h0);
    rd(8'h14, 8'h04, 8'h00);
    settle();
    `CHK(irq_q, 1'b0)
    q.push_back(17'h00100);
    apb(1'b0, 8'h2c, 32'h0);
    settle();
    final_report();
  end
endmodule
`default_nettype wire
